// ==== logic/status_event_publisher.sv ====
/*
 Status event publisher: maps internal signals onto two-bit status
 pairs, sends a multicast frame on every change and retransmits it on
 a schedule rising from the minimum to the maximum cycle time.
 Assumes a transmitter that takes a whole frame in one cycle while
 tx_ready is high, and synchronous inputs on the system clock.
*/
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - Up to 96 signals, two bits each
// - Pair codes configurable, default 00/01/10/11
// - 32 scheme pairs, then 64 user pairs
// - Any signal maps to any pair
// - Send fresh frame on any change
// - Resend after growing delay up to maximum
// - First retransmission after minimum cycle time
// - Retransmit gap never exceeds maximum
// - Every frame goes to multicast group
// - Schedule uses only min, max, increment
// - Validity equals twice maximum plus minimum
// - Increment sets rise rate of interval
module status_event_publisher #(
	parameter int N_SIGNALS = 128, // Internal signals offered for mapping
	parameter int TICK_LEN = status_event_publisher_pkg::TICK_CYCLES // Cycles per ms
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [N_SIGNALS-1:0] signal_in,
	input wire logic [status_event_publisher_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic tx_ready,
	output logic frame_send,
	output logic frame_retransmit,
	output logic [47:0] frame_dest,
	output logic [63:0] frame_scheme,
	output logic [127:0] frame_user,
	output logic [status_event_publisher_pkg::VALID_W-1:0] frame_validity_ms,
	output logic [15:0] frame_sequence,
	output logic irq
);
	import status_event_publisher_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic enable; // Publishing on
	logic [MS_W-1:0] min_cycle; // Minimum cycle time, ms
	logic [MS_W-1:0] max_retransmit_interval; // Maximum cycle time, ms
	logic [MS_W-1:0] increment; // Interval step, ms
	logic [7:0] encoding; // Pair code table
	logic [IRQ_W-1:0] irq_status; // Sticky events
	logic [IRQ_W-1:0] irq_mask; // Enabled events
	logic [47:0] dest; // Group address setting
	logic [7:0] map_mem [TOTAL_PAIRS]; // Signal select per pair
	sched_state_t state; // Scheduler state
	logic [MS_W-1:0] interval; // Wait before next retransmission
	logic [MS_W-1:0] wait_ms; // Elapsed ms in the current wait
	logic [31:0] tick_cnt; // Cycle count within a ms
	logic send_is_retx; // Pending send is a retransmission
	logic [2*TOTAL_PAIRS-1:0] last_pairs; // Pairs of the last frame sent
	logic [2*TOTAL_PAIRS-1:0] pairs; // Pairs as they stand now

	////////////////////////////////////////////////////////////////////////////////
	// Decoding

	// Register strobes per offset
	wire [7:0] word_idx = reg_addr[9:2]; // Word index of the register address
	wire hit_ctrl = reg_write && (reg_addr == REG_CONTROL);
	wire hit_min = reg_write && (reg_addr == REG_MIN_CYCLE);
	wire hit_max = reg_write && (reg_addr == REG_MAX_CYCLE);
	wire hit_incr = reg_write && (reg_addr == REG_INCREMENT);
	wire hit_enc = reg_write && (reg_addr == REG_ENCODING);
	wire hit_clr = reg_write && (reg_addr == REG_IRQ_STATUS);
	wire hit_mask = reg_write && (reg_addr == REG_IRQ_MASK);
	wire hit_dlo = reg_write && (reg_addr == REG_DEST_LOW);
	wire hit_dhi = reg_write && (reg_addr == REG_DEST_HIGH);

	// Two map entries per word would save space, but one entry per word keeps
	// software simple; the map holds 96 words from offset 0x100
	wire map_any = (reg_addr[9:8] == MAP_REGION) || (reg_addr[9:8] == 2'h2);
	wire [7:0] map_word = word_idx - 8'h40; // Entry number from 0x100
	wire map_ok = map_any && (map_word < 8'(TOTAL_PAIRS));
	wire map_wr = reg_write && map_ok;

	// Encode one pair from its map entry
	function automatic logic [1:0] encode_pair(input logic [7:0] entry,
		input logic [N_SIGNALS-1:0] sig, input logic [7:0] enc);
		logic [1:0] code;
		code = enc[ENC_UNKNOWN_LSB +: 2];
		if (entry[MAP_ENABLE_BIT]) begin
			if (32'(entry[MAP_SEL_W-1:0]) >= N_SIGNALS) begin
				code = enc[ENC_INVALID_LSB +: 2];
			end else if (sig[entry[MAP_SEL_W-1:0]]) begin
				code = enc[ENC_ON_LSB +: 2];
			end else begin
				code = enc[ENC_OFF_LSB +: 2];
			end
		end
		return code;
	endfunction

	// One encoder per pair, scheme pairs in the low slots
	genvar gi;
	generate
		for (gi = 0; gi < TOTAL_PAIRS; gi++) begin : g_pair
			assign pairs[2*gi +: 2] = encode_pair(map_mem[gi], signal_in, encoding);
		end
	endgenerate

	// Change and timing decisions
	wire changed = (pairs != last_pairs);
	wire tick = (tick_cnt == 32'(TICK_LEN - 1)); // One ms elapsed
	wire [MS_W:0] stepped = {1'b0, interval} + {1'b0, increment};
	wire [MS_W-1:0] next_interval = (stepped > {1'b0, max_retransmit_interval}) ?
		max_retransmit_interval : stepped[MS_W-1:0];
	wire wait_done = tick && ((wait_ms + 16'h0001) >= interval);
	// Gated by enable so that nothing leaves in the cycle after a disable write
	wire do_send = enable && (state == ST_SEND) && tx_ready;
	// A change that lands while a retransmission waits turns it into an event frame
	wire send_event = !send_is_retx || changed;
	wire [VALID_W-1:0] validity = {1'b0, max_retransmit_interval, 1'b0} +
		{2'b00, min_cycle};

	// Interrupt events this cycle
	wire [IRQ_W-1:0] irq_set = {
		do_send && !send_event && (interval == max_retransmit_interval),
		do_send && !send_event,
		do_send && send_event
	};
	// Mask as it stands after this edge, so irq follows a mask write at once
	wire [IRQ_W-1:0] next_irq_mask = hit_mask ? reg_wdata[IRQ_W-1:0] : irq_mask;
	wire [IRQ_W-1:0] next_irq_status = irq_set |
		(irq_status & ~(hit_clr ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));

	// Read data selection
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (reg_addr)
			REG_CONTROL: next_rdata = {31'h0, enable};
			REG_MIN_CYCLE: next_rdata = {16'h0000, min_cycle};
			REG_MAX_CYCLE: next_rdata = {16'h0000, max_retransmit_interval};
			REG_INCREMENT: next_rdata = {16'h0000, increment};
			REG_ENCODING: next_rdata = {24'h00_0000, encoding};
			REG_IRQ_STATUS: next_rdata = {29'h0, irq_status};
			REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
			REG_STATE: next_rdata = {14'h0000, state, interval};
			REG_DEST_LOW: next_rdata = dest[31:0];
			REG_DEST_HIGH: next_rdata = {16'h0000, dest[47:32]};
			REG_SEQUENCE: next_rdata = {16'h0000, frame_sequence};
			default: begin
				// Map entries, zero elsewhere
				if (map_ok) begin
					next_rdata = {24'h00_0000, map_mem[map_word[6:0]]};
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	// Settings written by software
	always_ff @(posedge clk) begin
		if (reset) begin
			enable <= 1'b0;
			min_cycle <= MIN_CYCLE_RESET;
			max_retransmit_interval <= MAX_CYCLE_RESET;
			increment <= INCREMENT_RESET;
			encoding <= ENCODING_RESET;
			irq_mask <= '0;
			dest <= DEST_RESET;
		end else begin
			if (hit_ctrl) enable <= reg_wdata[0];
			if (hit_min) min_cycle <= reg_wdata[MS_W-1:0];
			if (hit_max) max_retransmit_interval <= reg_wdata[MS_W-1:0];
			if (hit_incr) increment <= reg_wdata[MS_W-1:0];
			if (hit_enc) encoding <= reg_wdata[7:0];
			if (hit_mask) irq_mask <= reg_wdata[IRQ_W-1:0];
			if (hit_dlo) dest[31:0] <= reg_wdata;
			if (hit_dhi) dest[47:32] <= reg_wdata[15:0];
		end
	end

	// Signal map, disabled after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < TOTAL_PAIRS; i++) begin
				map_mem[i] <= 8'h00;
			end
		end else if (map_wr) begin
			map_mem[map_word[6:0]] <= reg_wdata[7:0];
		end
	end

	// Read data one cycle after the strobe, sticky status and irq
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
			irq_status <= next_irq_status; // Set wins over clear
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Retransmission scheduler

	// State and interval; only min, max and increment shape the timing
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			interval <= MIN_CYCLE_RESET;
			send_is_retx <= 1'b0;
		end else if (!enable) begin
			state <= ST_IDLE;
			send_is_retx <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					// Publish the present state once enabled
					state <= ST_SEND;
					interval <= min_cycle;
					send_is_retx <= 1'b0;
				end
				ST_SEND: begin
					// Hold until the transmitter takes the frame
					if (do_send) begin
						state <= ST_WAIT;
						if (changed) begin
							// Fresh pairs went out: time from the minimum
							interval <= min_cycle;
						end
					end
				end
				ST_WAIT: begin
					if (changed) begin
						// Abort the schedule and restart from minimum
						state <= ST_SEND;
						interval <= min_cycle;
						send_is_retx <= 1'b0;
					end else if (wait_done) begin
						state <= ST_SEND;
						interval <= next_interval;
						send_is_retx <= 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Millisecond base and elapsed count, restarted at each frame
	always_ff @(posedge clk) begin
		if (reset || state != ST_WAIT) begin
			tick_cnt <= 32'h0000_0000;
			wait_ms <= 16'h0000;
		end else if (tick) begin
			tick_cnt <= 32'h0000_0000;
			wait_ms <= wait_ms + 16'h0001;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame output

	// Capture the frame as it leaves, pulse the send strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			frame_send <= 1'b0;
			frame_retransmit <= 1'b0;
			frame_dest <= DEST_RESET;
			frame_scheme <= '0;
			frame_user <= '0;
			frame_validity_ms <= '0;
			frame_sequence <= 16'h0000;
			last_pairs <= '0;
		end else begin
			frame_send <= do_send;
			if (do_send) begin
				frame_retransmit <= !send_event;
				frame_dest <= dest | 48'(1 << GROUP_BIT);
				frame_scheme <= pairs[2*SCHEME_PAIRS-1:0];
				frame_user <= pairs[2*TOTAL_PAIRS-1:2*SCHEME_PAIRS];
				frame_validity_ms <= validity;
				frame_sequence <= frame_sequence + 16'h0001;
				last_pairs <= pairs;
			end
		end
	end

endmodule // status_event_publisher

// ==== shared/status_event_publisher_pkg.sv ====
/*
 Constants for the status event publisher: register offsets, field
 positions, reset values, state codes and timing counts.
 Assumes a 100 MHz system clock and a 32-bit register port.
*/
package status_event_publisher_pkg;

	// Clock and time base
	localparam int CLK_PERIOD_NS = 10; // System clock period
	localparam int MS_NS = 1000000; // One millisecond in ns
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS; // Cycles per ms tick

	// Payload layout
	localparam int SCHEME_PAIRS = 32; // Scheme protection pairs
	localparam int USER_PAIRS = 64; // User defined pairs
	localparam int TOTAL_PAIRS = SCHEME_PAIRS + USER_PAIRS; // Pairs per frame
	localparam int MS_W = 16; // Width of a time setting in ms
	localparam int VALID_W = 18; // Width of the validity field in ms
	localparam int ADDR_W = 10; // Register byte address width

	// Register byte offsets
	localparam logic [9:0] REG_CONTROL = 10'h000; // Enable
	localparam logic [9:0] REG_MIN_CYCLE = 10'h004; // Minimum cycle time, ms
	localparam logic [9:0] REG_MAX_CYCLE = 10'h008; // max_retransmit_interval, ms
	localparam logic [9:0] REG_INCREMENT = 10'h00c; // Step increment, ms
	localparam logic [9:0] REG_ENCODING = 10'h010; // Pair code table
	localparam logic [9:0] REG_IRQ_STATUS = 10'h014; // Sticky events, write one to clear
	localparam logic [9:0] REG_IRQ_MASK = 10'h018; // Interrupt mask
	localparam logic [9:0] REG_STATE = 10'h01c; // Current interval and state
	localparam logic [9:0] REG_DEST_LOW = 10'h020; // Group address bits 31:0
	localparam logic [9:0] REG_DEST_HIGH = 10'h024; // Group address bits 47:32
	localparam logic [9:0] REG_SEQUENCE = 10'h028; // Frames sent counter
	localparam logic [1:0] MAP_REGION = 2'h1; // Address bits 9:8 of map entries 0 to 63

	// Map entry fields
	localparam int MAP_ENABLE_BIT = 7; // Entry in use
	localparam int MAP_SEL_W = 7; // Signal index width

	// Encoding table field positions, two bits each
	localparam int ENC_UNKNOWN_LSB = 0;
	localparam int ENC_OFF_LSB = 2;
	localparam int ENC_ON_LSB = 4;
	localparam int ENC_INVALID_LSB = 6;

	// Reset values
	localparam logic [7:0] ENCODING_RESET = 8'he4; // 11 10 01 00
	localparam logic [15:0] MIN_CYCLE_RESET = 16'h000a; // 10 ms
	localparam logic [15:0] MAX_CYCLE_RESET = 16'h03e8; // 1000 ms
	localparam logic [15:0] INCREMENT_RESET = 16'h000a; // 10 ms
	localparam logic [47:0] DEST_RESET = 48'h0000_0000_0001; // Group bit set
	localparam int GROUP_BIT = 0; // Multicast bit of the first octet

	// Interrupt bits
	localparam int IRQ_EVENT_BIT = 0; // Event driven frame sent
	localparam int IRQ_RETX_BIT = 1; // Retransmission sent
	localparam int IRQ_MAX_BIT = 2; // Interval reached maximum
	localparam int IRQ_W = 3;

	// Scheduler states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10
	} sched_state_t;

endpackage

// ==== dv/status_event_publisher_asserts.sv ====
/*
 Port checker for the status event publisher.
 Assumes one clock and a bind at the foot.
*/
`timescale 1ns/100ps
module status_event_publisher_asserts #(
	parameter int TICK_LEN = 10 // Cycles per ms
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [status_event_publisher_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic frame_send,
	input wire logic frame_retransmit,
	input wire logic [47:0] frame_dest,
	input wire logic [status_event_publisher_pkg::VALID_W-1:0] frame_validity_ms,
	input wire logic [15:0] frame_sequence,
	input wire logic irq
);
	import status_event_publisher_pkg::*;
	logic en, mask0; // Shadow enable and event mask
	logic [15:0] mn, mx, inc; // Shadow settings
	int gap; // Cycles since last frame
	int iv; // Interval owed by next retransmission
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	// Settings as written
	always_ff @(posedge clk) begin
		if (reset) begin
			en <= 1'b0;
			mask0 <= 1'b0;
			mn <= MIN_CYCLE_RESET;
			mx <= MAX_CYCLE_RESET;
			inc <= INCREMENT_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				REG_CONTROL: en <= reg_wdata[0];
				REG_MIN_CYCLE: mn <= reg_wdata[15:0];
				REG_MAX_CYCLE: mx <= reg_wdata[15:0];
				REG_INCREMENT: inc <= reg_wdata[15:0];
				REG_IRQ_MASK: mask0 <= reg_wdata[IRQ_EVENT_BIT];
				default: ;
			endcase
		end
	end
	// Gap and expected interval, clamped at maximum
	always_ff @(posedge clk) begin
		if (reset || !en) begin
			gap <= 0;
			iv <= 0;
		end else if (frame_send) begin
			gap <= 0;
			iv <= !frame_retransmit ? int'(mn) :
				(iv + int'(inc) > int'(mx) ? int'(mx) : iv + int'(inc));
		end else begin
			gap <= gap + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	a_dest_multicast: assert property (frame_send |-> frame_dest[GROUP_BIT])
		else $error("frame without group bit");
	a_pulse_single: assert property (frame_send |=> !frame_send)
		else $error("frame pulse too long");
	a_validity_sum: assert property (frame_send |-> frame_validity_ms == 2 * mx + mn)
		else $error("validity wrong");
	a_sequence_step: assert property (frame_send |-> frame_sequence == $past(frame_sequence) + 16'h1)
		else $error("sequence skipped");
	a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside slot");
	a_max_readback: assert property (reg_read && reg_addr == REG_MAX_CYCLE |=> reg_rdata[15:0] == mx)
		else $error("max setting lost");
	a_gap_bound: assert property (en |-> gap <= mx * TICK_LEN + 12)
		else $error("gap above maximum");
	a_retx_interval: assert property (frame_send && frame_retransmit |->
		gap >= iv * TICK_LEN - 2 && gap <= iv * TICK_LEN + 12)
		else $error("retransmit interval wrong");
	a_irq_event: assert property (frame_send && !frame_retransmit && mask0 |-> ##[0:3] irq)
		else $error("irq missing");
endmodule // status_event_publisher_asserts

bind status_event_publisher status_event_publisher_asserts #(.TICK_LEN(TICK_LEN)) u_asserts (
	.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .frame_send(frame_send),
	.frame_retransmit(frame_retransmit), .frame_dest(frame_dest),
	.frame_validity_ms(frame_validity_ms), .frame_sequence(frame_sequence), .irq(irq));

// ==== dv/status_subscriber_model.sv ====
/*
 Subscriber model: paces tx_ready and expires received pairs.
 Assumes frames marked by frame_send with validity in ms.
*/
`timescale 1ns/100ps
module status_subscriber_model #(
	parameter int TICK_LEN = 10, // Cycles per ms
	parameter logic [63:0] SAFE_SCHEME = 64'h0 // Safe defaults, all unknown
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic frame_send,
	input wire logic [status_event_publisher_pkg::VALID_W-1:0] frame_validity_ms,
	input wire logic [63:0] frame_scheme,
	output logic tx_ready,
	output logic stale,
	output logic [63:0] held_scheme
);
	import status_event_publisher_pkg::*;
	int age; // Cycles since last frame
	int limit; // Expiry period in cycles
	logic [63:0] rx; // Last pairs seen
	assign stale = age > limit;
	assign held_scheme = stale ? SAFE_SCHEME : rx;
	// Stalls of one cycle at most; expiry restarts per frame
	always_ff @(posedge clk) begin
		if (reset) begin
			age <= 0;
			limit <= 0;
			rx <= SAFE_SCHEME;
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= !tx_ready || ($urandom % 4 != 0);
			age <= frame_send ? 0 : age + 1;
			if (frame_send) begin
				limit <= int'(frame_validity_ms) * TICK_LEN;
				rx <= frame_scheme;
			end
		end
	end
endmodule // status_subscriber_model

// ==== dv/tb.sv ====
/*
 Testbench: register port, frames, expiry and interrupt.
 Assumes the checker bind and subscriber model.
*/
`timescale 1ns/100ps
module tb;
	import status_event_publisher_pkg::*;
	localparam int NS = 100; // Signals offered
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [NS-1:0] signal_in = '0, nv;
	logic [9:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata;
	logic tx_ready, frame_send, frame_retransmit, irq, stale, rd_pend = 1'b0, quiet = 1'b0;
	logic [47:0] frame_dest;
	logic [63:0] frame_scheme, held_scheme;
	logic [127:0] frame_user;
	logic [17:0] frame_validity_ms;
	logic [15:0] frame_sequence;
	int errors = 0, samples_checked = 0, cycles = 0, nretx = 0;
	logic [31:0] rq[$]; // Expected reads
	logic [191:0] fq[$], last = '0; // Expected event frames
	logic men[96];
	logic [6:0] midx[96];
	logic [7:0] enc = 8'he4;
	always #5 clk = ~clk;
	status_event_publisher #(.N_SIGNALS(NS), .TICK_LEN(10)) u_dut (.clk(clk), .reset(reset),
		.signal_in(signal_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .tx_ready(tx_ready), .frame_send(frame_send),
		.frame_retransmit(frame_retransmit), .frame_dest(frame_dest), .frame_scheme(frame_scheme),
		.frame_user(frame_user), .frame_validity_ms(frame_validity_ms),
		.frame_sequence(frame_sequence), .irq(irq));
	status_subscriber_model #(.TICK_LEN(10)) u_sub (.clk(clk), .reset(reset),
		.frame_send(frame_send), .frame_validity_ms(frame_validity_ms),
		.frame_scheme(frame_scheme), .tx_ready(tx_ready), .stale(stale), .held_scheme(held_scheme));
	////////////////////////////////////////////////////////////////
	// Pairs of all 96 entries for signals s
	function automatic logic [191:0] exp_frame(logic [NS-1:0] s);
		logic [191:0] f;
		for (int e = 0; e < 96; e++) begin
			f[2*e +: 2] = !men[e] ? enc[1:0] : midx[e] >= NS ? enc[7:6] : s[midx[e]] ? enc[5:4] : enc[3:2];
		end
		return f;
	endfunction
	task automatic chk(string n, logic [191:0] e, logic [191:0] g);
		samples_checked++;
		if (e !== g) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [9:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(logic [9:0] a, logic [31:0] e);
		reg_addr <= a;
		reg_read <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		reg_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_frame();
		for (int i = 0; i < 2000 && frame_send !== 1'b1; i++) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Result watcher and timeout
	always @(posedge clk) begin
		cycles++;
		rd_pend <= reg_read;
		if (rd_pend) chk("reg_rdata", rq.pop_front(), reg_rdata);
		if (frame_send === 1'b1 && quiet) chk("frame while off", 0, 1);
		else if (frame_send === 1'b1 && frame_retransmit === 1'b0) begin
			last = fq.size() != 0 ? fq.pop_front() : 'x;
			chk("event frame", last, {frame_user, frame_scheme});
			chk("frame dest", 48'h0000_1234_5671, frame_dest);
		end else if (frame_send === 1'b1) begin
			nretx++;
			chk("retransmit", last, {frame_user, frame_scheme});
		end
		if (cycles == 40000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(74));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(REG_MIN_CYCLE, 32'ha);
		rd(REG_MAX_CYCLE, 32'h3e8);
		rd(REG_INCREMENT, 32'ha);
		rd(REG_ENCODING, 32'he4);
		rd(REG_DEST_LOW, 32'h1);
		for (int e = 0; e < 96; e++) begin
			men[e] = e == 0 || $urandom % 4 != 0;
			midx[e] = e == 0 ? 7'h5 : 7'($urandom);
			wr(10'h100 + 10'(4 * e), {24'h0, men[e], midx[e]});
		end
		wr(REG_MIN_CYCLE, 32'h2);
		wr(REG_MAX_CYCLE, 32'h7);
		wr(REG_INCREMENT, 32'h2);
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_DEST_LOW, 32'h1234_5670);
		rd(REG_DEST_LOW, 32'h1234_5670);
		nv = NS'({$urandom, $urandom, $urandom, $urandom});
		signal_in <= nv;
		fq.push_back(exp_frame(nv));
		wr(REG_CONTROL, 32'h1);
		for (int i = 0; i < 3000 && nretx < 6; i++) @(posedge clk);
		chk("live not expired", 0, stale);
		for (int k = 0; k < 6; k++) begin
			wait_frame();
			repeat (2 + $urandom % 12) @(posedge clk);
			nv = signal_in ^ NS'({$urandom, $urandom, $urandom, $urandom}) ^ NS'(32);
			signal_in <= nv;
			fq.push_back(exp_frame(nv));
		end
		wait_frame();
		@(posedge clk);
		enc = 8'h1b;
		fq.push_back(exp_frame(signal_in));
		wr(REG_ENCODING, {24'h0, enc});
		for (int i = 0; i < 400 && fq.size() != 0; i++) @(posedge clk);
		wr(REG_CONTROL, 32'h0);
		quiet <= 1'b1;
		repeat (250) @(posedge clk);
		chk("expired defaults", {1'b1, 64'h0}, {stale, held_scheme});
		rd(REG_IRQ_STATUS, 32'h7);
		chk("irq unmasked", 1, irq);
		wr(REG_IRQ_MASK, 32'h0);
		chk("irq masked", 0, irq);
		wr(REG_IRQ_STATUS, 32'h7);
		wr(REG_IRQ_MASK, 32'h7);
		rd(REG_IRQ_STATUS, 32'h0);
		chk("irq cleared", 0, irq);
		rd(10'h3fc, 32'h0);
		chk("event frames left", 0, fq.size());
		repeat (2) @(posedge clk);
		report_and_stop();
	end
endmodule // tb
